/* File: dv/ogcal_bench.sv */
// Self-checking bench of the calibration block.
`default_nettype none
module ogcal_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] OFS = 16'h0010;
	localparam logic [15:0] REFW = 16'h4100;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
	logic serialModePin = 1'b1, calibrateReqPin = 1'b0, resyncPin = 1'b0;
	logic lowPowerSelectPin = 1'b0, unipolarSelectPin_n = 1'b0;
	logic tbShared = 1'b1, wb_ack_o, validOrResyncPinOut;
	logic validOrResyncPinOe_n, wordReady_n, filterReset, filterStandby;
	logic calBusy, filterValid, bip = 1'b0, scoreOn = 1'b0, pend = 1'b0;
	logic pend2 = 1'b0;
	logic [1:0] modInputSel;
	logic [15:0] filterWord, dataWord, pinSample = 16'h0000;
	logic [15:0] ofsC = 16'h0000, gainC = 16'h0000;
	logic [15:0] expQ[$];
	int n_fail = 0, n_tests = 0, cycles = 0, busyLen = 0;
	wire logic validOrResyncPinIn;
	// Pull-up on the shared pin when nobody drives it.
	assign validOrResyncPinIn = !validOrResyncPinOe_n ?
		validOrResyncPinOut : tbShared;
	ogcal_top ogcal_top_inst (.clock, .rst_n, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_dat_o,
		.serialModePin, .calibrateReqPin, .resyncPin, .lowPowerSelectPin,
		.unipolarSelectPin_n, .validOrResyncPinIn, .validOrResyncPinOut,
		.validOrResyncPinOe_n, .wordReady_n, .filterWord, .filterValid,
		.filterReset, .filterStandby, .modInputSel, .dataWord, .calBusy);
	ogcal_filter_model #(.OFS_WORD(OFS), .REF_WORD(REFW))
		ogcal_filter_model_inst (.clock, .rst_n, .filterReset,
		.filterStandby, .modInputSel, .pinSample, .filterWord, .filterValid);
	// ==========================================================
	// Shared tasks.
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clock); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk(q, e);
	endtask
	task automatic waitBusy(input logic lvl);
		for (int i = 0; i < 12000 && calBusy !== lvl; i++) @(posedge clock);
	endtask
	task automatic serialCal();
		calibrateReqPin <= 1'b1;
		repeat (4) @(posedge clock);
		calibrateReqPin <= 1'b0;
		waitBusy(1'b1);
	endtask
	task automatic score(input int words);
		scoreOn <= 1'b1;
		repeat (words * 32) @(posedge clock);
		scoreOn <= 1'b0;
	endtask
	function automatic logic [15:0] corr(input logic [15:0] raw);
		int d;
		int y;
		d = int'(signed'(raw)) - int'(signed'(ofsC));
		y = d + ((d * int'(signed'(gainC))) >>> 14);
		y = y > 32767 ? 32767 : (y < -32768 ? -32768 : y);
		return bip ? y[15:0] : {~y[15], y[14:0]};
	endfunction
	// ==========================================================
	// Clock, random input, timeout and scoreboard.
	always #5 clock = ~clock;
	always @(posedge clock) begin
		pinSample <= 16'($urandom_range(32'h0000_0FFF, 0));
		if (calBusy === 1'b1) busyLen++;
		if (scoreOn && filterValid === 1'b1) expQ.push_back(corr(filterWord));
		cycles++;
		if (cycles == 60000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	always @(posedge clock) begin
		if (pend && expQ.size() > 0) begin
			chk(dataWord, expQ.pop_front());
		end
		if (pend2) begin
			chk(wordReady_n, 1'b1);
		end
		pend <= scoreOn && filterValid === 1'b1;
		pend2 <= pend;
	end
	// ==========================================================
	// Main sequence.
	initial begin
		void'($urandom(32'h8974));
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		repeat (12) @(posedge clock);
		rdchk(ogcal_pkg::ADDR_OFFSET, 32'h0000_0000);
		rdchk(ogcal_pkg::ADDR_GAIN, 32'h0000_0000);
		rdchk(ogcal_pkg::ADDR_STATUS, 32'h0000_0004);
		chk({validOrResyncPinOut, validOrResyncPinOe_n}, 2'b10);
		rdchk(8'h20, 32'h0000_0000);
		wb(1'b1, ogcal_pkg::ADDR_CTRL, 32'h0000_0200);
		rdchk(ogcal_pkg::ADDR_CTRL, 32'h0000_0200);
		wb(1'b1, ogcal_pkg::ADDR_CTRL, 32'h0000_0000);
		score(4);
		serialCal();
		repeat (200) @(posedge clock);
		resyncPin <= 1'b1;
		waitBusy(1'b0);
		resyncPin <= 1'b0;
		rdchk(ogcal_pkg::ADDR_OFFSET, 32'h0000_0000);
		repeat (2200) @(posedge clock);
		busyLen = 0;
		serialCal();
		waitBusy(1'b0);
		chk(busyLen <= 6720, 1);
		ofsC = OFS;
		gainC = 16'h4000 - (REFW - OFS);
		rdchk(ogcal_pkg::ADDR_OFFSET, {16'h0000, ofsC});
		rdchk(ogcal_pkg::ADDR_GAIN, {16'h0000, gainC});
		score(20);
		serialCal();
		repeat (300) @(posedge clock);
		lowPowerSelectPin <= 1'b1;
		waitBusy(1'b0);
		repeat (4) @(posedge clock);
		chk(filterStandby, 1'b1);
		rdchk(ogcal_pkg::ADDR_OFFSET, {16'h0000, ofsC});
		rdchk(ogcal_pkg::ADDR_GAIN, {16'h0000, gainC});
		lowPowerSelectPin <= 1'b0;
		repeat (2200) @(posedge clock);
		// A second reset brings the block up in parallel mode.
		rst_n <= 1'b0;
		serialModePin <= 1'b0;
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		repeat (8) @(posedge clock);
		bip = 1'b1;
		busyLen = 0;
		wb(1'b1, ogcal_pkg::ADDR_CTRL, 32'h0000_0006);
		do wb(1'b0, ogcal_pkg::ADDR_CTRL, 32'h0000_0000);
		while (q[1] === 1'b1 && busyLen < 9100);
		chk(q, 32'h0000_0004);
		chk(busyLen <= 9024, 1);
		rdchk(ogcal_pkg::ADDR_OFFSET, {16'h0000, ofsC});
		rdchk(ogcal_pkg::ADDR_GAIN, {16'h0000, gainC});
		score(20);
		wb(1'b1, ogcal_pkg::ADDR_CTRL, 32'h0000_000E);
		waitBusy(1'b1);
		chk(validOrResyncPinOe_n, 1'b1);
		tbShared <= 1'b0;
		repeat (100) @(posedge clock);
		tbShared <= 1'b1;
		waitBusy(1'b0);
		rdchk(ogcal_pkg::ADDR_CTRL, 32'h0000_000C);
		repeat (2200) @(posedge clock);
		tally_and_finish();
	end
endmodule
`default_nettype wire

/* File: dv/ogcal_filter_model.sv */
// Behavioural modulator and filter feeding the calibration block.
`default_nettype none
module ogcal_filter_model #(
	parameter logic [15:0] OFS_WORD = 16'h0010,
	parameter logic [15:0] REF_WORD = 16'h4100
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Control from the block.
	input wire logic filterReset,
	input wire logic filterStandby,
	input wire logic [1:0] modInputSel,
	input wire logic [15:0] pinSample,
	// Filter output.
	output logic [15:0] filterWord,
	output logic filterValid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] phase;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			phase <= 5'h00;
			filterValid <= 1'b0;
			filterWord <= 16'h0000;
		end else if (filterReset) begin
			phase <= 5'h00;
			filterValid <= 1'b0;
		end else if (!filterStandby) begin
			phase <= phase + 5'h01;
			filterValid <= (phase == 5'h1F);
			if (phase == 5'h1F) begin
				case (modInputSel)
					2'h1: filterWord <= OFS_WORD;
					2'h2: filterWord <= REF_WORD;
					default: filterWord <= pinSample;
				endcase
			end else begin
				// A stale word must never pass for a fresh one.
				filterWord <= ~filterWord;
			end
		end else begin
			filterValid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: dv/ogcal_top_sva.sv */
// Port-level concurrent checks of the calibration block.
`default_nettype none
module ogcal_top_sva #(
	parameter int W = 16,
	parameter logic [13:0] CAL_MAX_UNI = 14'h1A40,
	parameter logic [13:0] CAL_MAX_BI = 14'h2340
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Register bus.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// Device pins.
	input wire logic serialModePin,
	input wire logic resyncPin,
	input wire logic lowPowerSelectPin,
	input wire logic wordReady_n,
	// Filter side.
	input wire logic filterValid,
	input wire logic filterReset,
	input wire logic filterStandby,
	input wire logic [1:0] modInputSel,
	input wire logic [W-1:0] dataWord,
	input wire logic calBusy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// Counters, kept small so that long holds cost no unrolling.
	logic [11:0] holdCnt;
	logic [13:0] busyCnt;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			holdCnt <= 12'h000;
		end else if (filterReset) begin
			holdCnt <= 12'h001;
		end else if (holdCnt != 12'h000 && holdCnt < 12'h820) begin
			holdCnt <= holdCnt + 12'h001;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busyCnt <= 14'h0000;
		end else begin
			busyCnt <= calBusy ? busyCnt + 14'h0001 : 14'h0000;
		end
	end
	// ==========================================================
	// Properties.
	wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("ack late");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	route_busy_a: assert property (modInputSel != 2'h0
		|-> calBusy) else $error("input routed while idle");
	// Aborts leave routing in the same cycle busy falls, so only a clean
	// finish is held to the reconnect order.
	reconnect_pins_a: assert property ($fell(calBusy)
		&& !$past(filterReset) && !filterStandby
		|-> modInputSel == 2'h0 && $past(modInputSel) == 2'h0)
		else $error("pins not reconnected");
	ready_held_a: assert property (calBusy && $past(calBusy)
		|-> wordReady_n == !serialModePin) else $error("ready moved");
	resync_hold_a: assert property (holdCnt != 12'h000
		&& holdCnt < 12'h800 |-> wordReady_n == !serialModePin)
		else $error("ready released early");
	reset_pulse_a: assert property (filterReset
		|=> !filterReset) else $error("filter reset too long");
	cal_bound_a: assert property (busyCnt <= CAL_MAX_BI)
		else $error("calibration too long");
	sync_abort_a: assert property (calBusy && serialModePin
		&& $rose(resyncPin) |-> ##[1:12] filterReset ##[1:2] !calBusy)
		else $error("sync did not abort");
	low_power_select_abort_a: assert property (calBusy && serialModePin
		&& $rose(lowPowerSelectPin)
		|-> ##[1:12] (filterStandby && !calBusy))
		else $error("standby did not abort");
	keep_timing_a: assert property ($rose(calBusy)
		|-> !filterReset [*8]) else $error("calibration reset filter");
	data_hold_a: assert property (!filterValid
		|=> $stable(dataWord)) else $error("result changed without word");
endmodule
bind ogcal_top ogcal_top_sva #(.W(W), .CAL_MAX_UNI(CAL_MAX_UNI),
	.CAL_MAX_BI(CAL_MAX_BI)) ogcal_top_sva_inst (.clock, .rst_n,
	.wb_cyc_i, .wb_stb_i, .wb_ack_o, .serialModePin, .resyncPin,
	.lowPowerSelectPin, .wordReady_n, .filterValid, .filterReset,
	.filterStandby, .modInputSel, .dataWord, .calBusy);
`default_nettype wire

/* File: hdl/ogcal_datapath.sv */
// Offset subtraction, gain correction and output coding of filter words.
`default_nettype none
module ogcal_datapath #(
	parameter int W = 16
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Correction carrier.
	ogcal_corr_if.datapath bus
);
	// ==========================================================
	// Arithmetic.
	function automatic logic [W-1:0] satWord(input logic signed [W+1:0] v);
		logic signed [W+1:0] maxPos;
		logic signed [W+1:0] minNeg;
		maxPos = $signed({3'b000, {(W-1){1'b1}}});
		minNeg = ~maxPos;
		if (v > maxPos) begin
			satWord = maxPos[W-1:0];
		end else if (v < minNeg) begin
			satWord = minNeg[W-1:0];
		end else begin
			satWord = v[W-1:0];
		end
	endfunction

	logic signed [W:0] diff;
	logic signed [W:0] gainExt;
	logic signed [2*W+1:0] prod;
	logic signed [W+1:0] corr;
	logic [W-1:0] coded;

	assign diff = $signed({bus.rawWord[W-1], bus.rawWord})
		- $signed({bus.offsetCoef[W-1], bus.offsetCoef});
	assign gainExt = $signed({bus.gainCoef[W-1], bus.gainCoef});
	// A zero gain coefficient means unity gain, so a cleared register is safe.
	assign prod = diff * gainExt;
	assign corr = $signed({diff[W], diff})
		+ $signed(prod[ogcal_pkg::GAIN_SHIFT+W+1:ogcal_pkg::GAIN_SHIFT]);
	// Unipolar words are the signed result moved up by half scale.
	assign coded = bus.bipolar ? satWord(corr)
		: (satWord(corr) ^ {1'b1, {(W-1){1'b0}}});

	// ==========================================================
	// Output register.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bus.outWord <= '0;
			bus.outValid <= 1'b0;
		end else begin
			bus.outValid <= bus.rawValid;
			if (bus.rawValid) begin
				bus.outWord <= coded;
			end
		end
	end
endmodule
`default_nettype wire

/* File: hdl/ogcal_top.sv */
// Calibration sequencer, pin handling and register slave of the ADC filter.
`default_nettype none
// Contract
// - Calibration starts from serial pin or parallel bit.
// - Output is offset-subtracted, then gain-corrected.
// - Offset phase shorts inputs, averages eight words.
// - Gain phase applies reference, averages eight words.
// - Reconnect pins, settle before valid data.
// - Sequencing is internal; host only starts.
// - Cycle bounded: 6720 unipolar, 9024 bipolar.
// - Ready held high parallel, low serial.
// - Sync rising edge aborts calibration, resynchronises.
// - Standby aborts a running calibration.
// - Coefficients kept through standby, set by calibration.
// - Serial mode with cal pin low at power-up zeroes coefficients.
// - Calibration never resets filter word timing.
// - Bipolar output is two's complement.
// - Unipolar output is straight binary.
// - Calibrate bit self-clears; polarity bit selects mode.
// - Sync resets filter, ready held 2080 cycles.
module ogcal_top #(
	parameter int W = 16,
	parameter logic [13:0] CAL_MAX_UNI = ogcal_pkg::CAL_MAX_UNI_CYCLES,
	parameter logic [13:0] CAL_MAX_BI = ogcal_pkg::CAL_MAX_BI_CYCLES
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_n,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	// Device pins, asynchronous.
	input wire logic serialModePin,
	input wire logic calibrateReqPin,
	input wire logic resyncPin,
	input wire logic lowPowerSelectPin,
	input wire logic unipolarSelectPin_n,
	input wire logic validOrResyncPinIn,
	output logic validOrResyncPinOut,
	output logic validOrResyncPinOe_n,
	output logic wordReady_n,
	// Filter side, same clock.
	input wire logic [W-1:0] filterWord,
	input wire logic filterValid,
	output logic filterReset,
	output logic filterStandby,
	output logic [1:0] modInputSel,
	output logic [W-1:0] dataWord,
	output logic calBusy
);
	// ==========================================================
	// Pin synchronisers: a change counts once stages two and three agree.
	localparam int NP = ogcal_pkg::PIN_COUNT;
	logic [NP-1:0] pinRaw;
	logic [NP-1:0] pinS1;
	logic [NP-1:0] pinS2;
	logic [NP-1:0] pinS3;
	logic [NP-1:0] pinStable;
	logic [NP-1:0] pinPrev;
	logic [NP-1:0] pinRise;

	assign pinRaw = {serialModePin, validOrResyncPinIn, unipolarSelectPin_n,
		lowPowerSelectPin, resyncPin, calibrateReqPin};

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pinS1 <= '0;
			pinS2 <= '0;
			pinS3 <= '0;
			pinStable <= '0;
			pinPrev <= '0;
		end else begin
			pinS1 <= pinRaw;
			pinS2 <= pinS1;
			pinS3 <= pinS2;
			pinStable <= (pinS2 & pinS3) | (pinStable & (pinS2 ^ pinS3));
			pinPrev <= pinStable;
		end
	end
	assign pinRise = pinStable & ~pinPrev;

	// ==========================================================
	// Control register and mode selection.
	logic [31:0] ctrlReg;
	logic serialMode;
	logic calRequest;
	logic syncRise;
	logic standbyReq;
	logic bipolarSel;
	logic wbReq;
	logic wbWrite;

	assign wbReq = wb_cyc_i & wb_stb_i;
	// Writes land on the edge where the master sees ack.
	assign wbWrite = wbReq & wb_we_i & wb_ack_o;
	assign serialMode = pinStable[ogcal_pkg::PIN_SERIAL];
	assign calRequest = serialMode ? pinRise[ogcal_pkg::PIN_CAL]
		: ctrlReg[ogcal_pkg::CTRL_CALIBRATE_BIT];
	assign syncRise = serialMode ? pinRise[ogcal_pkg::PIN_SYNC]
		: (ctrlReg[ogcal_pkg::CTRL_SHARED_SYNC_BIT]
		& pinRise[ogcal_pkg::PIN_SHARED]);
	assign standbyReq = serialMode ? pinStable[ogcal_pkg::PIN_LOW_POWER_SELECT]
		: ctrlReg[ogcal_pkg::CTRL_STANDBY_BIT];
	assign bipolarSel = serialMode ? pinStable[ogcal_pkg::PIN_UNI_N]
		: ctrlReg[ogcal_pkg::CTRL_POLARITY_BIT];

	// ==========================================================
	// Sequencer.
	ogcal_pkg::ogcal_state_type state;
	logic [7:0] wordCnt;
	logic [13:0] cycCnt;
	logic [11:0] holdCnt;
	logic [W+2:0] accReg;
	logic [W+2:0] accSum;
	logic [W-1:0] mean;
	logic calBipolar;
	logic calActive;
	logic [7:0] settleWords;
	logic [13:0] cycLimit;
	logic lastAvg;
	logic lastSettle;
	logic finalDone;
	logic watchdogDone;
	logic abortCal;
	logic calEnd;
	logic calStart;
	logic offsetLoad;
	logic gainLoad;

	assign calActive = (state == ogcal_pkg::ST_OFF_SETTLE)
		|| (state == ogcal_pkg::ST_OFF_ACC)
		|| (state == ogcal_pkg::ST_GAIN_SETTLE)
		|| (state == ogcal_pkg::ST_GAIN_ACC)
		|| (state == ogcal_pkg::ST_FINAL_SETTLE);
	assign settleWords = calBipolar ? ogcal_pkg::SETTLE_BI_WORDS
		: ogcal_pkg::SETTLE_UNI_WORDS;
	assign cycLimit = calBipolar ? CAL_MAX_BI : CAL_MAX_UNI;
	assign lastAvg = filterValid
		&& (wordCnt == ogcal_pkg::AVERAGE_WORDS - 8'h01);
	assign lastSettle = filterValid && (wordCnt == settleWords - 8'h01);
	assign finalDone = (state == ogcal_pkg::ST_FINAL_SETTLE) && lastSettle;
	// Settling is counted in words; the watchdog keeps the cycle bounded
	// even if the filter stalls its word stream.
	assign watchdogDone = calActive
		&& (cycCnt == cycLimit - 14'h0001);
	assign abortCal = calActive && (standbyReq || syncRise);
	assign calEnd = finalDone || watchdogDone || abortCal;
	assign calStart = ((state == ogcal_pkg::ST_IDLE)
		|| (state == ogcal_pkg::ST_RESYNC))
		&& !standbyReq && !syncRise && calRequest;
	assign offsetLoad = (state == ogcal_pkg::ST_OFF_ACC) && lastAvg
		&& !calEnd;
	assign gainLoad = (state == ogcal_pkg::ST_GAIN_ACC) && lastAvg
		&& !calEnd;
	assign accSum = accReg + {{3{filterWord[W-1]}}, filterWord};
	assign mean = accSum[W-1+ogcal_pkg::AVERAGE_SHIFT:
		ogcal_pkg::AVERAGE_SHIFT];

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= ogcal_pkg::ST_IDLE;
			wordCnt <= '0;
			cycCnt <= '0;
			holdCnt <= '0;
			accReg <= '0;
			calBipolar <= 1'b0;
		end else if (standbyReq) begin
			state <= ogcal_pkg::ST_STANDBY;
		end else if (state == ogcal_pkg::ST_STANDBY) begin
			state <= ogcal_pkg::ST_RESYNC;
			holdCnt <= '0;
		end else if (syncRise) begin
			state <= ogcal_pkg::ST_RESYNC;
			holdCnt <= '0;
		end else if (calStart) begin
			state <= ogcal_pkg::ST_OFF_SETTLE;
			wordCnt <= '0;
			cycCnt <= '0;
			calBipolar <= bipolarSel;
		end else if (watchdogDone) begin
			state <= ogcal_pkg::ST_IDLE;
		end else begin
			if (calActive) begin
				cycCnt <= cycCnt + 14'h0001;
			end
			case (state)
				ogcal_pkg::ST_OFF_SETTLE: begin
					if (lastSettle) begin
						state <= ogcal_pkg::ST_OFF_ACC;
						wordCnt <= '0;
						accReg <= '0;
					end else if (filterValid) begin
						wordCnt <= wordCnt + 8'h01;
					end
				end
				ogcal_pkg::ST_OFF_ACC, ogcal_pkg::ST_GAIN_ACC: begin
					if (filterValid) begin
						accReg <= accSum;
						wordCnt <= wordCnt + 8'h01;
					end
					if (lastAvg) begin
						wordCnt <= '0;
						state <= (state == ogcal_pkg::ST_OFF_ACC)
							? ogcal_pkg::ST_GAIN_SETTLE
							: ogcal_pkg::ST_FINAL_SETTLE;
					end
				end
				ogcal_pkg::ST_GAIN_SETTLE: begin
					if (lastSettle) begin
						state <= ogcal_pkg::ST_GAIN_ACC;
						wordCnt <= '0;
						accReg <= '0;
					end else if (filterValid) begin
						wordCnt <= wordCnt + 8'h01;
					end
				end
				ogcal_pkg::ST_FINAL_SETTLE: begin
					if (lastSettle) begin
						state <= ogcal_pkg::ST_IDLE;
					end else if (filterValid) begin
						wordCnt <= wordCnt + 8'h01;
					end
				end
				ogcal_pkg::ST_RESYNC: begin
					holdCnt <= holdCnt + 12'h001;
					if (holdCnt == ogcal_pkg::RESYNC_HOLD_CYCLES - 12'h001) begin
						state <= ogcal_pkg::ST_IDLE;
					end
				end
				default: begin
					state <= state;
				end
			endcase
		end
	end

	// ==========================================================
	// Coefficients. They have no reset on purpose: they must survive
	// standby and are only defined once a calibration or the strap loads them.
	logic [W-1:0] offsetCoef;
	logic [W-1:0] gainCoef;
	logic [W:0] gainDiff;
	logic [W:0] gainErr;
	logic [2:0] strapCnt;
	logic strapTake;

	assign gainDiff = {mean[W-1], mean} - {offsetCoef[W-1], offsetCoef};
	assign gainErr = {1'b0, ogcal_pkg::GAIN_IDEAL} - gainDiff;
	assign strapTake = (strapCnt == ogcal_pkg::STRAP_WAIT - 3'h1);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			strapCnt <= '0;
		end else if (strapCnt != ogcal_pkg::STRAP_WAIT) begin
			strapCnt <= strapCnt + 3'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (strapTake && serialMode && !pinStable[ogcal_pkg::PIN_CAL]) begin
			offsetCoef <= '0;
			gainCoef <= '0;
		end else begin
			if (offsetLoad) begin
				offsetCoef <= mean;
			end
			if (gainLoad) begin
				gainCoef <= gainErr[W-1:0];
			end
		end
	end

	// ==========================================================
	// Correction datapath.
	ogcal_corr_if #(.W(W)) corr ();
	assign corr.rawWord = filterWord;
	assign corr.rawValid = filterValid;
	assign corr.offsetCoef = offsetCoef;
	assign corr.gainCoef = gainCoef;
	assign corr.bipolar = bipolarSel;
	assign dataWord = corr.outWord;

	ogcal_datapath #(.W(W)) u_datapath (
		.clock(clock),
		.rst_n(rst_n),
		.bus(corr.datapath)
	);

	// ==========================================================
	// Pin and filter outputs.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wordReady_n <= 1'b1;
			filterReset <= 1'b0;
			filterStandby <= 1'b0;
			modInputSel <= ogcal_pkg::INSEL_PINS;
			calBusy <= 1'b0;
			validOrResyncPinOut <= 1'b1;
			validOrResyncPinOe_n <= 1'b1;
		end else begin
			if (state != ogcal_pkg::ST_IDLE) begin
				wordReady_n <= !serialMode;
			end else begin
				wordReady_n <= corr.outValid;
			end
			// The filter is reset only on resync or standby, never by
			// calibration, so the word phase survives a calibration.
			filterReset <= (syncRise && !standbyReq)
				|| (state == ogcal_pkg::ST_STANDBY && !standbyReq);
			filterStandby <= standbyReq;
			if (state == ogcal_pkg::ST_OFF_SETTLE
				|| state == ogcal_pkg::ST_OFF_ACC) begin
				modInputSel <= ogcal_pkg::INSEL_SHORT;
			end else if (state == ogcal_pkg::ST_GAIN_SETTLE
				|| state == ogcal_pkg::ST_GAIN_ACC) begin
				modInputSel <= ogcal_pkg::INSEL_REF;
			end else begin
				modInputSel <= ogcal_pkg::INSEL_PINS;
			end
			calBusy <= calActive;
			validOrResyncPinOut <= 1'b1;
			validOrResyncPinOe_n <= !serialMode
				&& ctrlReg[ogcal_pkg::CTRL_SHARED_SYNC_BIT];
		end
	end

	// ==========================================================
	// Wishbone slave and control register.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrlReg <= ogcal_pkg::CTRL_RESET;
		end else begin
			if (wbWrite && wb_adr_i == ogcal_pkg::ADDR_CTRL && wb_sel_i[0]) begin
				ctrlReg[ogcal_pkg::CTRL_STANDBY_BIT] <=
					wb_dat_i[ogcal_pkg::CTRL_STANDBY_BIT];
				ctrlReg[ogcal_pkg::CTRL_POLARITY_BIT] <=
					wb_dat_i[ogcal_pkg::CTRL_POLARITY_BIT];
				ctrlReg[ogcal_pkg::CTRL_SHARED_SYNC_BIT] <=
					wb_dat_i[ogcal_pkg::CTRL_SHARED_SYNC_BIT];
			end
			if (wbWrite && wb_adr_i == ogcal_pkg::ADDR_CTRL && wb_sel_i[1]) begin
				ctrlReg[ogcal_pkg::CTRL_TEST_BIT] <=
					wb_dat_i[ogcal_pkg::CTRL_TEST_BIT];
			end
			// A new request written in the ending cycle is kept.
			if (wbWrite && wb_adr_i == ogcal_pkg::ADDR_CTRL && wb_sel_i[0]
				&& wb_dat_i[ogcal_pkg::CTRL_CALIBRATE_BIT]) begin
				ctrlReg[ogcal_pkg::CTRL_CALIBRATE_BIT] <= 1'b1;
			end else if (calEnd) begin
				ctrlReg[ogcal_pkg::CTRL_CALIBRATE_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wbReq && !wb_ack_o;
			if (!wbReq || wb_ack_o) begin
				wb_dat_o <= 32'h0000_0000;
			end else if (wb_adr_i == ogcal_pkg::ADDR_CTRL) begin
				wb_dat_o <= ctrlReg;
			end else if (wb_adr_i == ogcal_pkg::ADDR_STATUS) begin
				wb_dat_o <= 32'h0000_0000;
				wb_dat_o[ogcal_pkg::STAT_BUSY_BIT] <= calActive;
				wb_dat_o[ogcal_pkg::STAT_HOLD_BIT] <= state != ogcal_pkg::ST_IDLE;
				wb_dat_o[ogcal_pkg::STAT_SERIAL_BIT] <= serialMode;
				wb_dat_o[ogcal_pkg::STAT_STANDBY_BIT] <= standbyReq;
			end else if (wb_adr_i == ogcal_pkg::ADDR_OFFSET) begin
				wb_dat_o <= {{(32-W){1'b0}}, offsetCoef};
			end else if (wb_adr_i == ogcal_pkg::ADDR_GAIN) begin
				wb_dat_o <= {{(32-W){1'b0}}, gainCoef};
			end else if (wb_adr_i == ogcal_pkg::ADDR_RESULT) begin
				wb_dat_o <= {{(32-W){1'b0}}, corr.outWord};
			end else begin
				wb_dat_o <= 32'h0000_0000;
			end
		end
	end
endmodule
`default_nettype wire

/* File: include/ogcal_corr_if.sv */
// Carrier between the sequencer and the correction datapath.
`default_nettype none
interface ogcal_corr_if #(parameter int W = 16);
	logic [W-1:0] rawWord;
	logic rawValid;
	logic [W-1:0] offsetCoef;
	logic [W-1:0] gainCoef;
	logic bipolar;
	logic [W-1:0] outWord;
	logic outValid;
	modport ctrl (output rawWord, rawValid, offsetCoef, gainCoef, bipolar,
		input outWord, outValid);
	modport datapath (input rawWord, rawValid, offsetCoef, gainCoef,
		bipolar, output outWord, outValid);
endinterface
`default_nettype wire

/* File: include/ogcal_pkg.sv */
// Constants, register map and types of the offset and gain calibration block.
`default_nettype none
package ogcal_pkg;
	// ==========================================================
	// Register map, byte addresses on the Wishbone bus.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_OFFSET = 8'h08;
	localparam logic [7:0] ADDR_GAIN = 8'h0C;
	localparam logic [7:0] ADDR_RESULT = 8'h10;
	// ==========================================================
	// Control register fields.
	localparam int CTRL_STANDBY_BIT = 0;
	localparam int CTRL_CALIBRATE_BIT = 1;
	localparam int CTRL_POLARITY_BIT = 2;
	localparam int CTRL_SHARED_SYNC_BIT = 3;
	localparam int CTRL_TEST_BIT = 9;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// ==========================================================
	// Status register fields.
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_HOLD_BIT = 1;
	localparam int STAT_SERIAL_BIT = 2;
	localparam int STAT_STANDBY_BIT = 3;
	// ==========================================================
	// Synchronised pin indices.
	localparam int PIN_CAL = 0;
	localparam int PIN_SYNC = 1;
	localparam int PIN_LOW_POWER_SELECT = 2;
	localparam int PIN_UNI_N = 3;
	localparam int PIN_SHARED = 4;
	localparam int PIN_SERIAL = 5;
	localparam int PIN_COUNT = 6;
	// ==========================================================
	// Timing, all in master clock cycles or filter words.
	localparam logic [13:0] CAL_MAX_UNI_CYCLES = 14'h1A40;
	localparam logic [13:0] CAL_MAX_BI_CYCLES = 14'h2340;
	localparam logic [11:0] RESYNC_HOLD_CYCLES = 12'h0820;
	localparam logic [7:0] SETTLE_UNI_WORDS = 8'h40;
	localparam logic [7:0] SETTLE_BI_WORDS = 8'h58;
	localparam logic [7:0] AVERAGE_WORDS = 8'h08;
	localparam int AVERAGE_SHIFT = 3;
	localparam logic [2:0] STRAP_WAIT = 3'h5;
	// ==========================================================
	// Gain arithmetic: the ideal reference reading and its scale.
	localparam logic [15:0] GAIN_IDEAL = 16'h4000;
	localparam int GAIN_SHIFT = 14;
	// ==========================================================
	// Modulator input routing.
	localparam logic [1:0] INSEL_PINS = 2'h0;
	localparam logic [1:0] INSEL_SHORT = 2'h1;
	localparam logic [1:0] INSEL_REF = 2'h2;
	typedef enum {
		ST_IDLE,
		ST_OFF_SETTLE,
		ST_OFF_ACC,
		ST_GAIN_SETTLE,
		ST_GAIN_ACC,
		ST_FINAL_SETTLE,
		ST_RESYNC,
		ST_STANDBY
	} ogcal_state_type;
endpackage
`default_nettype wire
